// ---- rtl/cdc_setup_pkg.sv ----
// Constants shared by the channel setup register block of the capacitance converter.
// Assumes a single 20 MHz clock domain and an 8-bit register pointer space.
`default_nettype none

package cdc_setup_pkg;

	// Register pointers
	localparam logic [7:0] CAP_SETUP_ADDR = 8'h07;
	localparam logic [7:0] VOLT_TEMP_CHANNEL_SETUP_ADDR = 8'h08;
	localparam logic [7:0] EXCITATION_SETUP_ADDR = 8'h09;

	// Reset values
	localparam logic [7:0] CAP_SETUP_RESET = 8'h00;
	localparam logic [7:0] VOLT_TEMP_CHANNEL_SETUP_RESET = 8'h00;
	localparam logic [7:0] EXCITATION_SETUP_RESET = 8'h03;
	// Read answer for a pointer that holds no register
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Capacitive setup fields
	localparam int CAP_EN_BIT = 7;
	localparam int CAP_DIFF_BIT = 5;

	// Voltage/temperature setup fields
	localparam int VT_EN_BIT = 7;
	localparam int VT_SEL_HI_BIT = 6;
	localparam int VT_SEL_LO_BIT = 5;
	localparam int VT_REF_BIT = 4;
	localparam int VT_SHORT_BIT = 1;
	localparam int VT_CHOP_BIT = 0;

	// Excitation setup fields
	localparam int EXC_DAC_BIT = 3;
	localparam int EXC_EN_BIT = 2;
	localparam int EXC_LVL_HI_BIT = 1;
	localparam int EXC_LVL_LO_BIT = 0;

	// Voltage/temperature input choices
	typedef enum logic [1:0] {
		VT_IN_INT_TEMP = 2'b00,
		VT_IN_EXT_DIODE = 2'b01,
		VT_IN_SUPPLY_MON = 2'b10,
		VT_IN_EXT_VOLT = 2'b11
	} vt_input_t;

	// Excitation swing choices
	typedef enum logic [1:0] {
		EXC_SWING_EIGHTH = 2'b00,
		EXC_SWING_QUARTER = 2'b01,
		EXC_SWING_3_EIGHTHS = 2'b10,
		EXC_SWING_HALF = 2'b11
	} exc_level_t;

	// One-hot input path of the voltage/temperature channel
	localparam int VT_PATH_W = 5;
	localparam logic [4:0] PATH_INT_TEMP = 5'h01;
	localparam logic [4:0] PATH_EXT_DIODE = 5'h02;
	localparam logic [4:0] PATH_SUPPLY_MON = 5'h04;
	localparam logic [4:0] PATH_EXT_VOLT = 5'h08;
	localparam logic [4:0] PATH_SHORT = 5'h10;

	// Input path from select and short; short overrides any selection
	function automatic logic [4:0] vt_path(input vt_input_t sel, input logic short_in);
		logic [4:0] path;
		path = PATH_INT_TEMP;
		if (short_in) begin
			path = PATH_SHORT;
		end else begin
			unique case (sel)
				VT_IN_INT_TEMP: path = PATH_INT_TEMP;
				VT_IN_EXT_DIODE: path = PATH_EXT_DIODE;
				VT_IN_SUPPLY_MON: path = PATH_SUPPLY_MON;
				VT_IN_EXT_VOLT: path = PATH_EXT_VOLT;
			endcase
		end
		return path;
	endfunction

	// Inputs that only run against the internal reference
	function automatic logic needs_internal_ref(input vt_input_t sel);
		return (sel == VT_IN_INT_TEMP) || (sel == VT_IN_SUPPLY_MON);
	endfunction

endpackage

`default_nettype wire

// ---- rtl/ready_combiner.sv ----
// Combined conversion-ready term from the two per-channel ready flags.
// Assumes flags and enables come from the same clock; purely combinational.
`default_nettype none

module ready_combiner (
	input wire logic cap_enable_i,
	input wire logic vt_enable_i,
	input wire logic cap_ready_i,
	input wire logic vt_ready_i,
	output logic combined_o
);

	// A disabled channel does not hold the combined term back
	always_comb begin
		combined_o = (cap_enable_i || vt_enable_i)
			&& (cap_ready_i || !cap_enable_i)
			&& (vt_ready_i || !vt_enable_i);
	end

endmodule // ready_combiner

`default_nettype wire

// ---- rtl/cdc_channel_setup_regs.sv ----
// Channel setup registers of the capacitance converter and their control outputs.
// Assumes the serial interface logic delivers register accesses on this clock.
// Operation
// - Capacitive setup resets zero; top bit enables channel
// - Voltage/temperature setup resets zero; top bit enables
// - Bits 6:5 pick voltage/temperature channel input
// - Bit 4 picks reference; internal for internal inputs, a mismatch is only flagged
// - Bit 1 shorts voltage/temperature input for test
// - Bit 0 enables voltage/temperature chopping
// - Excitation setup resets to level all ones
// - Bit 3 enables offset DAC excitation
// - Bit 2 enables input and shield excitation
// - Bits 1:0 select excitation swing
// - Combined ready waits for all enabled channels
`default_nettype none

module cdc_channel_setup_regs (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic cap_conv_done_i,
	input wire logic vt_conv_done_i,
	input wire logic cap_data_read_i,
	input wire logic vt_data_read_i,
	output logic [7:0] reg_rdata_o,
	output logic cap_channel_enable_o,
	output logic cap_differential_bit_o,
	output logic vt_channel_enable_o,
	output cdc_setup_pkg::vt_input_t vt_input_sel_o,
	output logic [cdc_setup_pkg::VT_PATH_W-1:0] vt_path_o,
	output logic reference_source_sel_o,
	output logic reference_conflict_o,
	output logic vt_input_short_o,
	output logic vt_chopping_enable_o,
	output logic offset_dac_excitation_enable_o,
	output logic input_shield_excitation_enable_o,
	output cdc_setup_pkg::exc_level_t excitation_level_o,
	output logic cap_ready_o,
	output logic vt_ready_o,
	output logic conversion_ready_o
);
	import cdc_setup_pkg::*;

	logic [7:0] cap_setup; // Capacitive channel setup
	logic [7:0] volt_temp_channel_setup; // Voltage/temperature channel setup
	logic [7:0] excitation_setup; // Excitation setup
	logic [7:0] next_cap_setup;
	logic [7:0] next_volt_temp_channel_setup;
	logic [7:0] next_excitation_setup;
	logic [7:0] next_rdata;
	logic [4:0] next_path;
	logic next_conflict;
	logic cap_ready; // Capacitive result waiting
	logic vt_ready; // Voltage/temperature result waiting
	logic next_cap_ready;
	logic next_vt_ready;
	logic combined; // Combined ready before its register
	logic next_combined;
	vt_input_t vt_sel; // Selected input from the setup bits

	assign vt_sel = vt_input_t'(volt_temp_channel_setup[VT_SEL_HI_BIT:VT_SEL_LO_BIT]);

	// Register writes; reserved bits are stored as written so software reads back its value
	always_comb begin
		next_cap_setup = cap_setup;
		next_volt_temp_channel_setup = volt_temp_channel_setup;
		next_excitation_setup = excitation_setup;
		next_rdata = reg_rdata_o;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				CAP_SETUP_ADDR: next_cap_setup = reg_wdata_i;
				VOLT_TEMP_CHANNEL_SETUP_ADDR: next_volt_temp_channel_setup = reg_wdata_i;
				EXCITATION_SETUP_ADDR: next_excitation_setup = reg_wdata_i;
				default: ;
			endcase
		end
		// Read answer registered one cycle after the strobe
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				CAP_SETUP_ADDR: next_rdata = cap_setup;
				VOLT_TEMP_CHANNEL_SETUP_ADDR: next_rdata = volt_temp_channel_setup;
				EXCITATION_SETUP_ADDR: next_rdata = excitation_setup;
				default: next_rdata = UNMAPPED_READ;
			endcase
		end
	end

	// Register file storage, frozen while the clock enable is low
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			cap_setup <= CAP_SETUP_RESET;
			volt_temp_channel_setup <= VOLT_TEMP_CHANNEL_SETUP_RESET;
			excitation_setup <= EXCITATION_SETUP_RESET;
			reg_rdata_o <= UNMAPPED_READ;
		end else if (ce_i) begin
			cap_setup <= next_cap_setup;
			volt_temp_channel_setup <= next_volt_temp_channel_setup;
			excitation_setup <= next_excitation_setup;
			reg_rdata_o <= next_rdata;
		end
	end

	// Control outputs taken straight from the setup flops
	assign cap_channel_enable_o = cap_setup[CAP_EN_BIT];
	assign cap_differential_bit_o = cap_setup[CAP_DIFF_BIT];
	assign vt_channel_enable_o = volt_temp_channel_setup[VT_EN_BIT];
	assign vt_input_sel_o = vt_sel;
	assign reference_source_sel_o = volt_temp_channel_setup[VT_REF_BIT];
	assign vt_input_short_o = volt_temp_channel_setup[VT_SHORT_BIT];
	assign vt_chopping_enable_o = volt_temp_channel_setup[VT_CHOP_BIT];
	assign offset_dac_excitation_enable_o = excitation_setup[EXC_DAC_BIT];
	assign input_shield_excitation_enable_o = excitation_setup[EXC_EN_BIT];
	assign excitation_level_o = exc_level_t'(excitation_setup[EXC_LVL_HI_BIT:EXC_LVL_LO_BIT]);

	// Input path and reference check; the path lags the setup by one cycle
	always_comb begin
		next_path = vt_path(vt_sel, volt_temp_channel_setup[VT_SHORT_BIT]);
		// The device follows the bit; a bad combination is only flagged, not overridden
		next_conflict = volt_temp_channel_setup[VT_REF_BIT] && needs_internal_ref(vt_sel);
	end

	// Path and conflict registers
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			vt_path_o <= PATH_INT_TEMP;
			reference_conflict_o <= 1'b0;
		end else if (ce_i) begin
			vt_path_o <= next_path;
			reference_conflict_o <= next_conflict;
		end
	end

	// Per-channel ready flags; a finish in the same cycle as a read wins over the clear
	always_comb begin
		next_cap_ready = cap_ready;
		next_vt_ready = vt_ready;
		if (cap_data_read_i) begin
			next_cap_ready = 1'b0;
		end
		if (vt_data_read_i) begin
			next_vt_ready = 1'b0;
		end
		// A disabled channel produces no results
		if (cap_conv_done_i && cap_setup[CAP_EN_BIT]) begin
			next_cap_ready = 1'b1;
		end
		if (vt_conv_done_i && volt_temp_channel_setup[VT_EN_BIT]) begin
			next_vt_ready = 1'b1;
		end
		next_combined = combined;
	end

	ready_combiner u_ready_combiner (
		.cap_enable_i(cap_setup[CAP_EN_BIT]),
		.vt_enable_i(volt_temp_channel_setup[VT_EN_BIT]),
		.cap_ready_i(cap_ready),
		.vt_ready_i(vt_ready),
		.combined_o(combined)
	);

	// Ready flag registers
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			cap_ready <= 1'b0;
			vt_ready <= 1'b0;
			conversion_ready_o <= 1'b0;
		end else if (ce_i) begin
			cap_ready <= next_cap_ready;
			vt_ready <= next_vt_ready;
			conversion_ready_o <= next_combined;
		end
	end

	assign cap_ready_o = cap_ready;
	assign vt_ready_o = vt_ready;

	// Helper terms that only the checks read
	logic wr_cap;
	logic wr_vt;
	logic wr_exc;
	logic both_en;
	logic cap_only;
	logic [1:0] wdata_lvl;
	assign wr_cap = ce_i && reg_wr_i && (reg_addr_i == CAP_SETUP_ADDR);
	assign wr_vt = ce_i && reg_wr_i && (reg_addr_i == VOLT_TEMP_CHANNEL_SETUP_ADDR);
	assign wr_exc = ce_i && reg_wr_i && (reg_addr_i == EXCITATION_SETUP_ADDR);
	assign both_en = cap_setup[CAP_EN_BIT] && volt_temp_channel_setup[VT_EN_BIT];
	assign cap_only = cap_setup[CAP_EN_BIT] && !volt_temp_channel_setup[VT_EN_BIT];
	assign wdata_lvl = reg_wdata_i[EXC_LVL_HI_BIT:EXC_LVL_LO_BIT];

	cap_reset_a: assert property (@(posedge clock_i) !rst_b_i |=> cap_setup == CAP_SETUP_RESET
		&& !cap_channel_enable_o) else $error("capacitive setup not cleared by reset");
	cap_enable_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		wr_cap |=> cap_channel_enable_o == $past(reg_wdata_i[CAP_EN_BIT]))
		else $error("capacitive enable does not follow write");
	vt_reset_a: assert property (@(posedge clock_i) !rst_b_i |=> volt_temp_channel_setup == VOLT_TEMP_CHANNEL_SETUP_RESET
		&& !vt_channel_enable_o) else $error("voltage setup not cleared by reset");
	vt_path_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && !vt_input_short_o |=> $onehot(vt_path_o) && vt_path_o[$past(vt_sel)])
		else $error("input path does not match selection");
	ref_conflict_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && reference_source_sel_o && (vt_sel == VT_IN_SUPPLY_MON) |=> reference_conflict_o)
		else $error("reference conflict not flagged");
	vt_short_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && vt_input_short_o |=> vt_path_o == PATH_SHORT)
		else $error("short does not override input path");
	vt_chop_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		wr_vt |=> vt_chopping_enable_o == $past(reg_wdata_i[VT_CHOP_BIT]))
		else $error("chopping enable does not follow write");
	exc_reset_a: assert property (@(posedge clock_i) !rst_b_i |=> excitation_level_o == EXC_SWING_HALF
		&& !offset_dac_excitation_enable_o && !input_shield_excitation_enable_o)
		else $error("excitation setup reset wrong");
	exc_dac_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		wr_exc |=> offset_dac_excitation_enable_o == $past(reg_wdata_i[EXC_DAC_BIT]))
		else $error("offset DAC excitation does not follow write");
	exc_shield_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		wr_exc |=> input_shield_excitation_enable_o == $past(reg_wdata_i[EXC_EN_BIT]))
		else $error("input excitation does not follow write");
	exc_level_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		wr_exc |=> excitation_level_o == $past(wdata_lvl))
		else $error("excitation level does not follow write");
	both_ready_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(rst_b_i) && $past(ce_i) && $past(both_en) && !$past(vt_ready) |-> !conversion_ready_o)
		else $error("combined ready before both channels");
	single_ready_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$past(rst_b_i) && $past(ce_i) && $past(cap_only) |-> conversion_ready_o == $past(cap_ready))
		else $error("combined ready does not track capacitive flag");

endmodule // cdc_channel_setup_regs

`default_nettype wire

// ---- verification/cdc_host_model.sv ----
// Host model that programs the setup registers through the register strobes.
// Assumes the bench calls its tasks; all changes land on falling clock edges.
`default_nettype none

module cdc_host_model (
	input wire logic clock_i,
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_rd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import cdc_setup_pkg::*;

	// Quiet bus at time zero
	initial begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_wdata_o = 8'h00;
		reg_rd_o = 1'b0;
	end

	// One write pulse; data is scrambled afterwards so a stale value never looks valid
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clock_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask

	// One read pulse; the answer is taken by the bench monitor
	task automatic get(input logic [7:0] a);
		@(negedge clock_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clock_i);
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
	endtask

	// Recommended programming of all three registers, both channels on
	task automatic proper();
		put(CAP_SETUP_ADDR, 8'hA0);
		put(VOLT_TEMP_CHANNEL_SETUP_ADDR, 8'hE1);
		put(EXCITATION_SETUP_ADDR, 8'h0E);
	endtask
endmodule // cdc_host_model

`default_nettype wire

// ---- verification/cdc_channel_setup_regs_tb.sv ----
// Self-checking bench for the channel setup registers and ready flags.
// Assumes the host model drives the register port; bench drives the rest.
`default_nettype none

module cdc_channel_setup_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cdc_setup_pkg::*;

	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic ce_i = 1'b1;
	logic [3:0] evt = 4'h0; // Bits: vt read, cap read, vt done, cap done
	logic [7:0] reg_addr, reg_wdata, rdata, d;
	logic reg_wr, reg_rd, cap_en, cap_diff, vt_en, ref_sel, conflict, v_short, chop;
	logic dac_exc, active_shield_output_exc, cap_rdy, vt_rdy, conv_rdy;
	logic [4:0] path;
	vt_input_t vt_sel;
	exc_level_t lvl;
	int n_fail = 0;
	int cmp_count = 0;
	logic [7:0] exp_q[$]; // Expected read answers, oldest first
	logic took = 1'b0;
	logic [31:0] seed = 32'h8179;

	always #25 clock_i = ~clock_i;

	cdc_host_model host (.clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
		.reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));

	cdc_channel_setup_regs dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
		.reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
		.cap_conv_done_i(evt[0]), .vt_conv_done_i(evt[1]), .cap_data_read_i(evt[2]),
		.vt_data_read_i(evt[3]), .reg_rdata_o(rdata), .cap_channel_enable_o(cap_en),
		.cap_differential_bit_o(cap_diff), .vt_channel_enable_o(vt_en), .vt_input_sel_o(vt_sel),
		.vt_path_o(path), .reference_source_sel_o(ref_sel), .reference_conflict_o(conflict),
		.vt_input_short_o(v_short), .vt_chopping_enable_o(chop),
		.offset_dac_excitation_enable_o(dac_exc), .input_shield_excitation_enable_o(active_shield_output_exc),
		.excitation_level_o(lvl), .cap_ready_o(cap_rdy), .vt_ready_o(vt_rdy),
		.conversion_ready_o(conv_rdy));

	// Fixed-seed xorshift for write data
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// Seen value first, then the value the rules call for
	task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Note the answer, then issue the read
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.get(a);
	endtask

	// One-cycle pulse on the flag event inputs
	task automatic ev(input logic [3:0] v);
		@(negedge clock_i);
		evt = v;
		@(negedge clock_i);
		evt = 4'h0;
	endtask

	task automatic wrap_up();
		// A noted read answer that never showed up is a mismatch too
		if (exp_q.size() != 0) begin
			n_fail++;
		end
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Monitor: a taken read shows its answer one cycle later
	always @(posedge clock_i) begin
		took <= reg_rd && ce_i && rst_b_i;
	end
	always @(negedge clock_i) begin
		if (took && exp_q.size() > 0) begin
			chk("rdata", rdata, exp_q.pop_front());
		end
	end

	// Watchdog, far beyond the roughly 120 cycles the sequence needs
	initial begin
		repeat (5000) @(posedge clock_i);
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (16) @(negedge clock_i);
		rst_b_i = 1'b1;
		rd_exp(CAP_SETUP_ADDR, 8'h00);
		rd_exp(VOLT_TEMP_CHANNEL_SETUP_ADDR, 8'h00);
		rd_exp(EXCITATION_SETUP_ADDR, 8'h03);
		chk("level", {6'h00, lvl}, 8'h03);
		chk("path", {3'h0, path}, 8'h01);
		// Frozen clock enable drops the write; unmapped pointer stays empty
		ce_i = 1'b0;
		host.put(VOLT_TEMP_CHANNEL_SETUP_ADDR, 8'h80);
		ce_i = 1'b1;
		rd_exp(VOLT_TEMP_CHANNEL_SETUP_ADDR, 8'h00);
		host.put(8'h0A, xs());
		rd_exp(8'h0A, 8'h00);
		// Random contents with every input and swing code forced once
		for (int k = 0; k < 12; k++) begin
			d = xs();
			d[6:5] = k[1:0];
			d[1:0] = k[1:0];
			// Short only on the internal sensor, so every other input path is seen unshorted
			if (k % 3 == 1) begin
				d[1] = (k == 4);
				d[4] = (k > 5);
			end
			host.put(8'h07 + 8'(k % 3), d);
			@(negedge clock_i);
			if (k % 3 == 0) begin
				chk("cap_en", {7'h0, cap_en}, {7'h0, d[7]});
				chk("cap_diff", {7'h0, cap_diff}, {7'h0, d[5]});
			end else if (k % 3 == 1) begin
				chk("vt_fields", {vt_en, vt_sel, ref_sel, 2'b00, v_short, chop}, d & 8'hF3);
				chk("path", {3'h0, path}, d[1] ? 8'h10 : 8'h01 << d[6:5]);
				chk("conflict", {7'h0, conflict}, {7'h0, d[4] & ~d[5]});
				chk("chop", {7'h0, chop}, {7'h0, d[0]});
			end else begin
				chk("exc", {4'h0, dac_exc, active_shield_output_exc, lvl}, d & 8'h0F);
			end
			rd_exp(8'h07 + 8'(k % 3), d);
		end
		// Ready flags with both channels enabled
		host.proper();
		ev(4'b0001);
		@(negedge clock_i);
		chk("ready_one", {6'h0, cap_rdy, conv_rdy}, 8'h02);
		ev(4'b0010);
		@(negedge clock_i);
		chk("ready_both", {5'h0, cap_rdy, vt_rdy, conv_rdy}, 8'h07);
		ev(4'b0100);
		@(negedge clock_i);
		chk("ready_read", {5'h0, cap_rdy, vt_rdy, conv_rdy}, 8'h02);
		ev(4'b0101);
		chk("done_wins", {7'h0, cap_rdy}, 8'h01);
		// Voltage channel off: combined follows the capacitive flag alone
		host.put(VOLT_TEMP_CHANNEL_SETUP_ADDR, 8'h01);
		ev(4'b1010);
		@(negedge clock_i);
		chk("cap_only", {6'h0, vt_rdy, conv_rdy}, 8'h01);
		ev(4'b0100);
		@(negedge clock_i);
		chk("cap_only_clr", {7'h0, conv_rdy}, 8'h00);
		repeat (2) @(negedge clock_i);
		wrap_up();
	end
endmodule // cdc_channel_setup_regs_tb

`default_nettype wire
